// ==== design/sensor_i2c_regs.svh ====
// register offsets, reset values and constants of the sensor i2c register port
`ifndef SENSOR_I2C_REGS_SVH
`define SENSOR_I2C_REGS_SVH

`define SLAVE_ADDR          7'h1a
`define OFS_BLACK_HIGH      16'h0008
`define OFS_BLACK_LOW       16'h0009
`define OFS_STANDBY         16'h0100
`define OFS_ORIENT          16'h0101
`define OFS_HOLD            16'h0104
`define RST_BLACK_LOW       8'h40
`define RST_BLACK_HIGH      1'b0
`define RST_STANDBY         1'b0
`define RST_ORIENT          2'h0
`define RST_HOLD            1'b1
`define BIT_HFLIP           0
`define BIT_VFLIP           1

`endif

// ==== design/sensor_i2c_pkg.sv ====
// types of the sensor i2c register port
package sensor_i2c_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_DEVA  = 3'b001,
        ST_DEVK  = 3'b011,
        ST_RXB   = 3'b010,
        ST_RXK   = 3'b110,
        ST_TXB   = 3'b111,
        ST_TXK   = 3'b101,
        ST_WAIT  = 3'b100
    } link_state_t;

    typedef struct packed {
        logic       normal_run;
        logic       horizontal_flip;
        logic       vertical_flip;
        logic [8:0] black_offset;
    } sensor_cfg_t;

endpackage

// ==== design/sensor_i2c_register_port.sv ====
// i2c slave register port with index pointer and frame reflection
`timescale 1ns/1ps
`include "sensor_i2c_regs.svh"

// Overview of operation
// - message is 16-bit address then data bytes
// - bytes msb first, each followed by ack bit
// - data changes only while clock low
// - start is data falling while clock high
// - start without stop continues, index kept
// - receiver acks then releases data line
// - write address bytes load the index
// - index increments at each data ack
// - read address acked, byte at index follows
// - master ack continues read, nack ends
// - write data acked and index incremented
// - frame settings apply at frame reflection point
// - immediate registers apply at write time
// - hold bit set defers frame reflection
// - clearing hold applies held settings together
// - black offset nine bits, default 040h, immediate
// - standby bit zero is standby, resets zero
// - orientation flips, reset zero, frame reflected
// - slave address 0011010, eighth bit direction
// - protocol fixed first transaction; chip enable high
module sensor_i2c_register_port (
    input  wire logic                      clock_i,
    input  wire logic                      rst_i,
    input  wire logic                      scl_i,
    input  wire logic                      sda_i,
    input  wire logic                      serial_chip_enable_n_i,
    input  wire logic                      frame_reflect_i,
    output logic                           sda_o,
    output logic                           sda_oe_o,
    output logic                           i2c_selected_o,
    output sensor_i2c_pkg::sensor_cfg_t    cfg_o
);

    // pin synchronisers, two flops per pin before any logic reads them
    // idle level is high, so leaving reset shows no false edge on either line
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [1:0] cen_sync;
    logic       scl_d;
    logic       sda_d;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            cen_sync <= 2'h3;
            scl_d    <= 1'b1;
            sda_d    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], scl_i};
            sda_sync <= {sda_sync[0], sda_i};
            cen_sync <= {cen_sync[0], serial_chip_enable_n_i};
            scl_d    <= scl_sync[1];
            sda_d    <= sda_sync[1];
        end
    end

    // bus events, seen on the synchronised copies a few cycles behind the pins
    wire scl   = scl_sync[1];
    wire sda   = sda_sync[1];
    wire rise  = scl & ~scl_d;
    wire fall  = ~scl & scl_d;
    wire start = scl & scl_d & sda_d & ~sda;
    wire stop  = scl & scl_d & ~sda_d & sda;

    // protocol lock: i2c chosen on first start while chip enable held high
    // a low chip enable at that start keeps the port dark until reset
    logic locked;
    logic lock_i2c;

    // the first start of the run decides the protocol
    wire lock_now = !locked && start;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            locked   <= 1'b0;
            lock_i2c <= 1'b0;
        end else if (lock_now) begin
            locked   <= 1'b1;
            lock_i2c <= cen_sync[1];
        end
    end

    wire active = lock_i2c | (~locked & cen_sync[1]);

    // link state
    sensor_i2c_pkg::link_state_t state;
    sensor_i2c_pkg::link_state_t next_state;
    logic [2:0]  bit_cnt;
    logic [7:0]  shreg;
    logic [1:0]  rx_cnt;   // bytes received since address: 0,1 address, 2 data
    logic        dir_rd;
    logic [15:0] index;
    logic        master_nack;

    // live registers and pending frame-reflected copies
    logic [7:0] black_low;
    logic       black_high;
    logic       standby_run;
    logic       hold;
    logic [1:0] orient_shadow;
    logic [1:0] orient_live;

    // read mux, unmapped addresses read as zero
    function automatic logic [7:0] reg_read(input logic [15:0] a);
        unique case (a)
            `OFS_BLACK_LOW:  reg_read = black_low;
            `OFS_BLACK_HIGH: reg_read = {7'h00, black_high};
            `OFS_STANDBY:    reg_read = {7'h00, standby_run};
            `OFS_ORIENT:     reg_read = {6'h00, orient_shadow};
            `OFS_HOLD:       reg_read = {7'h00, hold};
            default:         reg_read = 8'h00;
        endcase
    endfunction

    wire [7:0] rx_byte  = {shreg[6:0], sda};
    wire       addr_hit = (rx_byte[7:1] == `SLAVE_ADDR);
    wire       last_bit = (bit_cnt == 3'h7);
    wire       wr_data  = (state == sensor_i2c_pkg::ST_RXB) && rise && last_bit
                          && (rx_cnt == 2'h2);
    wire [7:0] rd_byte  = reg_read(index);

    // state decodes shared by the bit engine, the index pointer and the driver
    wire in_deva = (state == sensor_i2c_pkg::ST_DEVA);
    wire in_devk = (state == sensor_i2c_pkg::ST_DEVK);
    wire in_rxb  = (state == sensor_i2c_pkg::ST_RXB);
    wire in_rxk  = (state == sensor_i2c_pkg::ST_RXK);
    wire in_txb  = (state == sensor_i2c_pkg::ST_TXB);
    wire in_txk  = (state == sensor_i2c_pkg::ST_TXK);

    // byte boundaries on the write side: two address bytes, then data
    wire rx_done = in_rxb && rise && last_bit;
    wire addr_hi = rx_done && (rx_cnt == 2'h0);
    wire addr_lo = rx_done && (rx_cnt == 2'h1);

    // master answer bit after a read byte; ack or nack both advance the index
    wire rd_answer = in_txk && rise;

    // read bit select: a new byte starts at its msb, each later fall moves one
    // bit lower; the counter still holds the old position at that fall
    wire [2:0] tx_pos = in_txb ? (3'h6 - bit_cnt) : 3'h7;
    wire       tx_bit = rd_byte[tx_pos];

    // ack slot: opens at the fall that ends a byte, closes at the next fall
    wire ack_slot = (in_devk || in_rxk) && (bit_cnt == 3'h0);
    wire tx_drive = (next_state == sensor_i2c_pkg::ST_TXB);

    // open-drain drive values taken at each clock fall
    wire next_sda    = tx_drive & tx_bit;
    wire next_sda_oe = ack_slot | (tx_drive & ~tx_bit);

    // next state on scl edges
    always_comb begin
        next_state = state;
        unique case (state)
            sensor_i2c_pkg::ST_IDLE: next_state = state;
            sensor_i2c_pkg::ST_DEVA:
                if (rise && last_bit)
                    next_state = addr_hit ? sensor_i2c_pkg::ST_DEVK
                                          : sensor_i2c_pkg::ST_WAIT;
            sensor_i2c_pkg::ST_DEVK:
                if (fall && bit_cnt == 3'h1)
                    next_state = dir_rd ? sensor_i2c_pkg::ST_TXB
                                        : sensor_i2c_pkg::ST_RXB;
            sensor_i2c_pkg::ST_RXB:
                if (rise && last_bit) next_state = sensor_i2c_pkg::ST_RXK;
            sensor_i2c_pkg::ST_RXK:
                if (fall && bit_cnt == 3'h1) next_state = sensor_i2c_pkg::ST_RXB;
            sensor_i2c_pkg::ST_TXB:
                if (fall && last_bit) next_state = sensor_i2c_pkg::ST_TXK;
            sensor_i2c_pkg::ST_TXK:
                if (fall)
                    next_state = master_nack ? sensor_i2c_pkg::ST_WAIT
                                             : sensor_i2c_pkg::ST_TXB;
            sensor_i2c_pkg::ST_WAIT: next_state = state;
            default: next_state = sensor_i2c_pkg::ST_IDLE;
        endcase
    end

    // bit engine: start/stop override the scl-driven progress
    // a start or stop may come at any bit, so both take priority here
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state       <= sensor_i2c_pkg::ST_IDLE;
            bit_cnt     <= 3'h0;
            shreg       <= 8'h00;
            rx_cnt      <= 2'h0;
            dir_rd      <= 1'b0;
            master_nack <= 1'b0;
        end else if (!active || stop) begin
            state <= sensor_i2c_pkg::ST_IDLE;
        end else if (start) begin
            state   <= sensor_i2c_pkg::ST_DEVA;
            bit_cnt <= 3'h0;
        end else begin
            state <= next_state;
            // sample one bit per rise while receiving
            if (rise && (in_deva || in_rxb)) begin
                shreg   <= rx_byte;
                bit_cnt <= bit_cnt + 3'h1;
            end
            // direction latched with the last address bit
            if (in_deva && rise && last_bit) begin
                dir_rd <= rx_byte[0];
                rx_cnt <= 2'h0;
            end
            // ack slot spans two falls: the one that opens and the one that closes it
            if (fall && (in_devk || in_rxk)) begin
                bit_cnt <= (bit_cnt == 3'h0) ? 3'h1 : 3'h0;
            end
            // count address bytes, saturating once data begins
            if (rx_done && rx_cnt != 2'h2) begin
                rx_cnt <= rx_cnt + 2'h1;
            end
            // one bit per fall while sending
            if (in_txb && fall) begin
                bit_cnt <= bit_cnt + 3'h1;
            end
            // master answer after a read byte
            if (rd_answer) begin
                master_nack <= sda;
            end
            // the fall after the answer bit starts the next byte afresh
            if (in_txk && fall) begin
                bit_cnt <= 3'h0;
            end
        end
    end

    // index pointer
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            index <= 16'h0000;
        end else if (addr_hi) begin
            index <= {rx_byte, index[7:0]};
        end else if (addr_lo) begin
            index <= {index[15:8], rx_byte};
        end else if (wr_data || rd_answer) begin
            index <= index + 16'h0001;
        end
    end

    // data line driver: ack low, read data msb first, released otherwise
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            sda_o    <= 1'b1;
            sda_oe_o <= 1'b0;
        end else if (start || stop || !active) begin
            // a start or stop always frees the line
            sda_oe_o <= 1'b0;
        end else if (fall) begin
            // the line only moves while the clock is low
            sda_o    <= next_sda;
            sda_oe_o <= next_sda_oe;
        end
    end

    // write strobes decoded from the index, one per mapped register
    wire wr_black_low  = wr_data && (index == `OFS_BLACK_LOW);
    wire wr_black_high = wr_data && (index == `OFS_BLACK_HIGH);
    wire wr_standby    = wr_data && (index == `OFS_STANDBY);
    wire wr_orient     = wr_data && (index == `OFS_ORIENT);
    wire wr_hold       = wr_data && (index == `OFS_HOLD);

    // black offset low byte, applied at once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            black_low <= `RST_BLACK_LOW;
        end else if (wr_black_low) begin
            black_low <= rx_byte;
        end
    end

    // black offset bit 8, applied at once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            black_high <= `RST_BLACK_HIGH;
        end else if (wr_black_high) begin
            black_high <= rx_byte[0];
        end
    end

    // standby control, applied at once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            standby_run <= `RST_STANDBY;
        end else if (wr_standby) begin
            standby_run <= rx_byte[0];
        end
    end

    // orientation pending copy, waits for the frame point
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            orient_shadow <= `RST_ORIENT;
        end else if (wr_orient) begin
            orient_shadow <= rx_byte[1:0];
        end
    end

    // reflection hold, applied at once
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            hold <= `RST_HOLD;
        end else if (wr_hold) begin
            hold <= rx_byte[0];
        end
    end

    // frame reflection point moves pending values unless held
    // only the orientation is frame reflected; hold stops the copy
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            orient_live <= `RST_ORIENT;
        end else if (frame_reflect_i && !hold) begin
            orient_live <= orient_shadow;
        end
    end

    // registered outputs
    // straight from flops so the far side never sees decode glitches
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_o          <= '0;
            i2c_selected_o <= 1'b0;
        end else begin
            cfg_o.normal_run      <= standby_run;
            cfg_o.horizontal_flip <= orient_live[`BIT_HFLIP];
            cfg_o.vertical_flip   <= orient_live[`BIT_VFLIP];
            cfg_o.black_offset    <= {black_high, black_low};
            i2c_selected_o        <= lock_i2c;
        end
    end

endmodule // sensor_i2c_register_port

// ==== testbench/sensor_i2c_port_chk.sv ====
// assertion checker on the pins of the sensor i2c register port
`timescale 1ns/1ps
module sensor_i2c_port_chk (
    input  wire logic                        clock_i,
    input  wire logic                        rst_i,
    input  wire logic                        scl_i,
    input  wire logic                        sda_i,
    input  wire logic                        serial_chip_enable_n_i,
    input  wire logic                        frame_reflect_i,
    input  wire logic                        sda_o,
    input  wire logic                        sda_oe_o,
    input  wire logic                        i2c_selected_o,
    input  wire sensor_i2c_pkg::sensor_cfg_t cfg_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    // reset values, open drain, data line timing and protocol lock
    reset_cfg_a: assert property ($fell(rst_i) |=> cfg_o == 12'h040)
        else $error("cfg not at reset value");
    drive_low_a: assert property (sda_oe_o |-> !sda_o)
        else $error("data line driven high");
    oe_scl_low_a: assert property ($changed(sda_oe_o) |-> !scl_i)
        else $error("data drive changed while clock high");
    ack_stands_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*4])
        else $error("drive too short");
    stop_release_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |=> !sda_oe_o [*8])
        else $error("drive after stop");
    sel_keep_a: assert property (i2c_selected_o |=> i2c_selected_o)
        else $error("protocol lock lost");
    sel_gate_a: assert property (!i2c_selected_o |-> !sda_oe_o)
        else $error("drive while not selected");
    sel_enable_a: assert property ($rose(i2c_selected_o) |-> serial_chip_enable_n_i)
        else $error("lock with chip enable low");
    flip_frame_a: assert property ($changed({cfg_o.horizontal_flip, cfg_o.vertical_flip})
        |-> $past(frame_reflect_i) || $past(frame_reflect_i, 2))
        else $error("flip changed off frame point");
endmodule // sensor_i2c_port_chk

// ==== testbench/i2c_host_model.sv ====
// i2c host model: bit-level open-drain master on a pulled-up line
`timescale 1ns/1ps
module i2c_host_model (
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      pull_o
);
    int ph = 50; // clock phase in ns, lowered for fast traffic

    // idle bus: both lines released high
    initial begin
        scl_o = 1'b1;
        pull_o = 1'b0;
    end
    // one bit out, data moved only while clock low
    task automatic put(input logic b);
        #10 pull_o = !b;
        #(ph - 10) scl_o = 1'b1;
        #ph scl_o = 1'b0;
    endtask
    // one bit in, line released first
    task automatic get(output logic b);
        #10 pull_o = 1'b0;
        #(ph - 10) scl_o = 1'b1;
        #(ph / 2) b = sda_i;
        #(ph / 2) scl_o = 1'b0;
    endtask
    // byte out msb first, then the answer bit
    task automatic wbyte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) put(d[i]);
        get(ack);
    endtask
    // byte in, then ack or nack
    task automatic rbyte(output logic [7:0] d, input logic nack);
        for (int i = 7; i >= 0; i--) get(d[i]);
        put(nack);
    endtask
    // start or repeated start
    task automatic start();
        #10 pull_o = 1'b0;
        #(ph - 10) scl_o = 1'b1;
        #ph pull_o = 1'b1;
        #ph scl_o = 1'b0;
    endtask
    // stop, leaves the bus idle
    task automatic stop();
        #10 pull_o = 1'b1;
        #(ph - 10) scl_o = 1'b1;
        #ph pull_o = 1'b0;
        #ph;
    endtask
endmodule // i2c_host_model

// ==== testbench/sensor_i2c_register_port_tb.sv ====
// self-checking bench for the sensor i2c register port
`timescale 1ns/1ps
module sensor_i2c_register_port_tb;
    logic                        clk, rst, frame, ce_n, sda_o, sda_oe, sel, k;
    sensor_i2c_pkg::sensor_cfg_t cfg;
    logic [7:0]                  mem [0:511];
    logic [1:0]                  fl;
    logic [31:0]                 r;
    int                          idx, mismatches, n_checks;
    wire                         scl, pull;
    wire                         sda = !(pull || (sda_oe && !sda_o));

    i2c_host_model u_host (.sda_i(sda), .scl_o(scl), .pull_o(pull));
    sensor_i2c_register_port u_sensor_i2c_register_port (.clock_i(clk), .rst_i(rst),
        .scl_i(scl), .sda_i(sda), .serial_chip_enable_n_i(ce_n), .frame_reflect_i(frame),
        .sda_o(sda_o), .sda_oe_o(sda_oe), .i2c_selected_o(sel), .cfg_o(cfg));

    // 200 mhz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    // bus byte compare
    task automatic chk_bus(input string n, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    // configuration compare against the model
    task automatic chk_cfg();
        logic [11:0] e;
        e = {mem[256][0], fl[0], fl[1], mem[8][0], mem[9]};
        n_checks++;
        if (cfg !== e) begin
            mismatches++;
            $display("[FAIL] cfg exp %h got %h", e, cfg);
        end
    endtask
    // stored width of each mapped register
    function automatic logic [7:0] msk(input int a);
        case (a)
            9: msk = 8'hff;
            8, 256, 260: msk = 8'h01;
            257: msk = 8'h03;
            default: msk = 8'h00;
        endcase
    endfunction
    // byte out with expected answer bit
    task automatic tx(input logic [7:0] b, input logic e);
        u_host.wbyte(b, k);
        chk_bus("ack", {7'h0, e}, {7'h0, k});
    endtask
    // address phase, no stop
    task automatic seek(input logic [15:0] a);
        u_host.start();
        tx(8'h34, 1'b0);
        tx(a[15:8], 1'b0);
        tx(a[7:0], 1'b0);
        idx = a;
    endtask
    // sequential write, fixed bits kept zero by the caller
    task automatic wr(input logic [15:0] a, input logic [7:0] d [$]);
        seek(a);
        foreach (d[i]) begin
            tx(d[i], 1'b0);
            mem[idx % 512] = d[i] & msk(idx);
            idx++;
        end
        u_host.stop();
    endtask
    // read n bytes from the current index
    task automatic rd(input int n);
        logic [7:0] v;
        u_host.start();
        tx(8'h35, 1'b0);
        for (int i = 0; i < n; i++) begin
            u_host.rbyte(v, i == n - 1);
            chk_bus("data", mem[idx % 512], v);
            idx++;
        end
        u_host.stop();
    endtask
    // frame reflection pulse, sent only between transfers
    task automatic frm();
        @(posedge clk);
        #1 frame = 1'b1;
        @(posedge clk);
        #1 frame = 1'b0;
        if (!mem[260][0]) fl = mem[257][1:0];
        repeat (3) @(posedge clk);
        #1;
    endtask
    // verdict and end of run
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        #400000;
        mismatches++;
        results();
    end
    // main sequence
    initial begin
        r = $urandom(78570);
        {rst, frame, ce_n, mismatches, n_checks, idx, fl} = {3'b101, 96'h0, 2'h0};
        foreach (mem[i]) mem[i] = 8'h00;
        mem[9] = 8'h40;
        mem[260] = 8'h01;
        repeat (3) @(posedge clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk_cfg();
        seek(16'h0008);
        rd(3);
        seek(16'h0100);
        rd(5);
        chk_bus("sel", 8'h01, {7'h0, sel});
        wr(16'h0100, '{8'h01, 8'h03});
        chk_cfg();
        frm();
        chk_cfg();
        wr(16'h0104, '{8'h00});
        chk_cfg();
        frm();
        chk_cfg();
        u_host.ph = 30;
        repeat (4) begin
            r = $urandom();
            wr(16'h0008, '{{7'h0, r[8]}, r[7:0]});
            chk_cfg();
            seek(16'h0008);
            rd(2);
        end
        seek(16'h0009);
        u_host.stop();
        rd(1);
        rd(1);
        u_host.start();
        tx(8'h36, 1'b1);
        u_host.stop();
        rd(1);
        results();
    end
endmodule // sensor_i2c_register_port_tb

bind sensor_i2c_register_port sensor_i2c_port_chk u_chk (.clock_i(clock_i), .rst_i(rst_i),
    .scl_i(scl_i), .sda_i(sda_i), .serial_chip_enable_n_i(serial_chip_enable_n_i),
    .frame_reflect_i(frame_reflect_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .i2c_selected_o(i2c_selected_o), .cfg_o(cfg_o));
